// [pkg/acs_consts.svh]
/*
 * Constants of the serial clock-source and extension control block:
 * register offsets, field positions, reset values and divider figures.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_EXT0_ADDR     8'h12
`define ACS_EXT1_ADDR     8'h13
`define ACS_BCTL0_ADDR    8'h02
`define ACS_BCTL1_ADDR    8'h03

`define ACS_EXT_RXINT_BIT 7
`define ACS_EXT_DCD_BIT   6
`define ACS_EXT_CTS_BIT   5
`define ACS_EXT_X1_BIT    4
`define ACS_EXT_BRG_BIT   3
`define ACS_EXT_BRKEN_BIT 2
`define ACS_EXT_BRKDT_BIT 1
`define ACS_EXT_SNDBK_BIT 0
`define ACS_EXT_RESET     8'h00
`define ACS_EXT0_WMASK    8'hfd
`define ACS_EXT1_WMASK    8'h9d

`define ACS_BCTL_PS_BIT   5
`define ACS_BCTL_DR_BIT   3
`define ACS_BCTL_SS_LSB   0
`define ACS_BCTL_RESET    8'h07
`define ACS_BCTL_WMASK    8'h2f

`define ACS_PRESCALE_LO   17'h0000a
`define ACS_PRESCALE_HI   17'h0001e
`define ACS_RATIO_LO_LIM  6'h0f
`define ACS_RATIO_HI_LIM  6'h3f

`endif

// [pkg/acs_pkg.sv]
/*
 * Types shared by the serial clock-source control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acs_pkg;
    typedef logic [7:0]  acs_byte_t;
    typedef logic [15:0] acs_tc_t;
    typedef enum logic [2:0] {
        ACS_SS_DIV1  = 3'b000,
        ACS_SS_DIV2  = 3'b001,
        ACS_SS_DIV4  = 3'b010,
        ACS_SS_DIV8  = 3'b011,
        ACS_SS_DIV16 = 3'b100,
        ACS_SS_DIV32 = 3'b101,
        ACS_SS_DIV64 = 3'b110,
        ACS_SS_EXT   = 3'b111
    } acs_ss_t;
endpackage : acs_pkg

// [src/acs_baud.sv]
/*
 * Baud tick generator for one serial channel: sampling tick and bit tick.
 * Assumes CLK_I domain inputs; the external clock is a synchronous level.
 */
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_baud (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           reset_i,
    input  wire logic           ce_i,
    // Configuration
    input  wire acs_pkg::acs_ss_t ss_i,
    input  wire logic           ps_i,
    input  wire logic           dr_i,
    input  wire logic           x1_i,
    input  wire logic           brg_i,
    input  wire acs_pkg::acs_tc_t tc_i,
    input  wire logic           ext_clk_i,
    // Ticks
    output logic                sample_tick_o,
    output logic                bit_tick_o
);
    import acs_pkg::*;

    logic [16:0] cnt_reg, cnt_next, lim, pre;
    logic [5:0]  div_reg, div_next, div_lim;
    logic        prev_reg, prev_next, samp_next, bit_next, ext;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ext = (ss_i == ACS_SS_EXT);
        pre = ps_i ? `ACS_PRESCALE_HI : `ACS_PRESCALE_LO;
        // Product stays below 4096, so 17 bits never overflow
        lim = brg_i ? {1'b0, tc_i}
                    : 17'((pre << ss_i) - 17'h00001);
        div_lim = dr_i ? `ACS_RATIO_HI_LIM : `ACS_RATIO_LO_LIM;
        cnt_next = cnt_reg;
        div_next = div_reg;
        prev_next = ext_clk_i;
        samp_next = 1'b0;
        bit_next = 1'b0;
        if (ext) begin
            cnt_next = '0;
            samp_next = ext_clk_i & ~prev_reg;
        end else if (cnt_reg >= lim) begin
            cnt_next = '0;
            samp_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 17'h00001;
        end
        if (samp_next) begin
            if (ext && x1_i) begin
                bit_next = 1'b1;
            end else if (div_reg >= div_lim) begin
                div_next = '0;
                bit_next = 1'b1;
            end else begin
                div_next = div_reg + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_reg       <= '0;
            div_reg       <= '0;
            prev_reg      <= 1'b0;
            sample_tick_o <= 1'b0;
            bit_tick_o    <= 1'b0;
        end else if (ce_i) begin
            cnt_reg       <= cnt_next;
            div_reg       <= div_next;
            prev_reg      <= prev_next;
            sample_tick_o <= samp_next;
            bit_tick_o    <= bit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_x1_direct: assert property (@(posedge clk_i)
        disable iff (reset_i)
        ce_i && ext && x1_i && ext_clk_i && !prev_reg |=> bit_tick_o)
        else $error("x1 mode did not pass the external edge as bit tick");
    a_ext_no_count: assert property (@(posedge clk_i)
        disable iff (reset_i)
        ce_i && ext && !ext_clk_i |=> !sample_tick_o)
        else $error("sample tick without external clock edge");
endmodule : acs_baud

// [src/acs_ctrl.sv]
/*
 * Clock-source selection, pin routing and extension control for two
 * asynchronous serial channels, reached over the I/O register port.
 * Assumes all inputs synchronous to CLK_I; shifters live elsewhere.
 */
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_ctrl (
    // Clock, reset, enable
    input  wire logic              CLK_I,
    input  wire logic              RESET_I,
    input  wire logic              CE_I,
    // I/O register port
    input  wire logic [7:0]        IO_ADDR_I,
    input  wire logic              IO_WR_I,
    input  wire logic              IO_RD_I,
    input  wire acs_pkg::acs_byte_t IO_WDATA_I,
    output acs_pkg::acs_byte_t     IO_RDATA_O,
    // DMA controller side
    input  wire logic              CH1_CLOCK_PIN_DISABLE_I,
    input  wire logic              DMA0_MEM_IO_I,
    input  wire logic              DMA_TRANSFER_END_OUTPUT_0_I,
    output logic                   DMA_REQUEST_INPUT_0_O,
    // Shared data clock pins
    input  wire logic              CH0_DATA_CLOCK_PIN_I,
    output logic                   CH0_DATA_CLOCK_PIN_O,
    output logic                   CH0_DATA_CLOCK_PIN_OE_O,
    input  wire logic              CH1_DATA_CLOCK_PIN_I,
    output logic                   CH1_DATA_CLOCK_PIN_O,
    output logic                   CH1_DATA_CLOCK_PIN_OE_O,
    // Modem lines of channel 0
    input  wire logic              CARRIER_DETECT_INPUT_0_I,
    input  wire logic              CLEAR_TO_SEND_INPUT_0_I,
    // Time constants held elsewhere
    input  wire acs_pkg::acs_tc_t  TIME_CONST0_I,
    input  wire acs_pkg::acs_tc_t  TIME_CONST1_I,
    // Channel side, bit n is channel n
    input  wire logic [1:0]        TX_DATA_I,
    input  wire logic [1:0]        RECEIVE_FULL_FLAG_I,
    input  wire logic [1:0]        TRANSMIT_EMPTY_FLAG_I,
    input  wire logic [1:0]        BREAK_SEEN_I,
    output logic [1:0]             ASYNC_TRANSMIT_PIN_O,
    output logic [1:0]             RECEIVE_FULL_FLAG_O,
    output logic [1:0]             TRANSMIT_EMPTY_FLAG_O,
    output logic [1:0]             RX_INT_O,
    output logic [1:0]             RX_ENABLE_O,
    output logic [1:0]             TX_ENABLE_O,
    output logic [1:0]             SAMPLE_TICK_O,
    output logic [1:0]             BIT_TICK_O
);
    import acs_pkg::*;

    acs_byte_t  ext_reg  [2];
    acs_byte_t  ext_next [2];
    acs_byte_t  bctl_reg [2];
    acs_byte_t  bctl_next[2];
    acs_byte_t  rdata_next;
    logic [1:0] txp_next;
    logic       ch1_out_next;
    logic [1:0] ext_clk;
    logic [1:0] hit_ext, hit_bctl;
    acs_tc_t    tc [2];

    assign tc[0] = TIME_CONST0_I;
    assign tc[1] = TIME_CONST1_I;

    ////////////////////////////////////////////////////////////////////////
    // Pin routing; channel-0 pin is an input in both of its roles
    assign CH0_DATA_CLOCK_PIN_OE_O = 1'b0;
    assign CH0_DATA_CLOCK_PIN_O    = 1'b0;
    assign DMA_REQUEST_INPUT_0_O   = DMA0_MEM_IO_I
                                     & CH0_DATA_CLOCK_PIN_I;
    assign CH1_DATA_CLOCK_PIN_OE_O = CH1_CLOCK_PIN_DISABLE_I;
    // A pin lent to the DMA never clocks the channel
    assign ext_clk[0] = ~DMA0_MEM_IO_I & CH0_DATA_CLOCK_PIN_I;
    assign ext_clk[1] = ~CH1_CLOCK_PIN_DISABLE_I
                        & CH1_DATA_CLOCK_PIN_I;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel registers and gating
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            localparam acs_byte_t EXT_ADDR =
                (c == 0) ? `ACS_EXT0_ADDR : `ACS_EXT1_ADDR;
            localparam acs_byte_t BCTL_ADDR =
                (c == 0) ? `ACS_BCTL0_ADDR : `ACS_BCTL1_ADDR;
            localparam acs_byte_t EXT_WMASK =
                (c == 0) ? `ACS_EXT0_WMASK : `ACS_EXT1_WMASK;
            logic brk_set;

            assign hit_ext[c]  = (IO_ADDR_I == EXT_ADDR);
            assign hit_bctl[c] = (IO_ADDR_I == BCTL_ADDR);

            always_comb begin
                ext_next[c]  = ext_reg[c];
                bctl_next[c] = bctl_reg[c];
                brk_set = BREAK_SEEN_I[c]
                          & ~ext_reg[c][`ACS_EXT_BRKEN_BIT];
                if (IO_WR_I && hit_ext[c]) begin
                    ext_next[c] = (IO_WDATA_I & EXT_WMASK)
                        | (ext_reg[c] & ~EXT_WMASK);
                end
                if (IO_WR_I && hit_bctl[c]) begin
                    bctl_next[c] = IO_WDATA_I & `ACS_BCTL_WMASK;
                end
                // Break status clears on read; a new break wins
                if (IO_RD_I && hit_ext[c]) begin
                    ext_next[c][`ACS_EXT_BRKDT_BIT] = 1'b0;
                end
                if (brk_set) begin
                    ext_next[c][`ACS_EXT_BRKDT_BIT] = 1'b1;
                end
                txp_next[c] = TX_DATA_I[c]
                    & ~ext_reg[c][`ACS_EXT_SNDBK_BIT];
            end

            always_ff @(posedge CLK_I) begin
                if (RESET_I) begin
                    ext_reg[c]  <= `ACS_EXT_RESET;
                    bctl_reg[c] <= `ACS_BCTL_RESET;
                    ASYNC_TRANSMIT_PIN_O[c] <= 1'b1;
                end else if (CE_I) begin
                    ext_reg[c]  <= ext_next[c];
                    bctl_reg[c] <= bctl_next[c];
                    ASYNC_TRANSMIT_PIN_O[c] <= txp_next[c];
                end
            end

            assign RX_INT_O[c] = RECEIVE_FULL_FLAG_I[c]
                & ext_reg[c][`ACS_EXT_RXINT_BIT];

            acs_baud u_baud (
                .clk_i         (CLK_I),
                .reset_i       (RESET_I),
                .ce_i          (CE_I),
                .ss_i          (acs_ss_t'(bctl_reg[c][2:0])),
                .ps_i          (bctl_reg[c][`ACS_BCTL_PS_BIT]),
                .dr_i          (bctl_reg[c][`ACS_BCTL_DR_BIT]),
                .x1_i          (ext_reg[c][`ACS_EXT_X1_BIT]),
                .brg_i         (ext_reg[c][`ACS_EXT_BRG_BIT]),
                .tc_i          (tc[c]),
                .ext_clk_i     (ext_clk[c]),
                .sample_tick_o (SAMPLE_TICK_O[c]),
                .bit_tick_o    (BIT_TICK_O[c])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Modem gating, channel 0 only; channel 1 runs ungated
    always_comb begin
        RX_ENABLE_O[0] = ext_reg[0][`ACS_EXT_DCD_BIT]
                         | ~CARRIER_DETECT_INPUT_0_I;
        TX_ENABLE_O[0] = ext_reg[0][`ACS_EXT_CTS_BIT]
                         | ~CLEAR_TO_SEND_INPUT_0_I;
        RX_ENABLE_O[1] = 1'b1;
        TX_ENABLE_O[1] = 1'b1;
        RECEIVE_FULL_FLAG_O[0] = RECEIVE_FULL_FLAG_I[0] & RX_ENABLE_O[0];
        RECEIVE_FULL_FLAG_O[1] = RECEIVE_FULL_FLAG_I[1];
        // The flag is held whatever bit 5 says; TX_ENABLE_O[0] drops only with bit 5 clear
        TRANSMIT_EMPTY_FLAG_O[0] = TRANSMIT_EMPTY_FLAG_I[0]
                                   & ~CLEAR_TO_SEND_INPUT_0_I;
        TRANSMIT_EMPTY_FLAG_O[1] = TRANSMIT_EMPTY_FLAG_I[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and channel-1 DMA end output
    always_comb begin
        rdata_next = IO_RDATA_O;
        if (IO_RD_I) begin
            rdata_next = 8'h00;
            for (int i = 0; i < 2; i++) begin
                if (hit_ext[i]) begin
                    rdata_next = ext_reg[i];
                end
                if (hit_bctl[i]) begin
                    rdata_next = bctl_reg[i];
                end
            end
        end
        ch1_out_next = CH1_CLOCK_PIN_DISABLE_I
                       & DMA_TRANSFER_END_OUTPUT_0_I;
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            IO_RDATA_O           <= 8'h00;
            CH1_DATA_CLOCK_PIN_O <= 1'b0;
        end else if (CE_I) begin
            IO_RDATA_O           <= rdata_next;
            CH1_DATA_CLOCK_PIN_O <= ch1_out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    a_reset_values: assert property ($fell(RESET_I) |->
        bctl_reg[0] == 8'h07 && bctl_reg[1] == 8'h07 && ext_reg[0] == 8'h00)
        else $error("clock control reset values wrong");
    a_ratio_prescale_rst: assert property ($fell(RESET_I) |->
        !bctl_reg[1][3] && !bctl_reg[1][5])
        else $error("divide ratio or prescale not clear after reset");
    a_ch0_pin_input: assert property (!CH0_DATA_CLOCK_PIN_OE_O)
        else $error("channel-0 clock pin driven");
    a_dma_request: assert property (DMA0_MEM_IO_I |->
        DMA_REQUEST_INPUT_0_O == CH0_DATA_CLOCK_PIN_I)
        else $error("DMA request does not follow channel-0 pin");
    // The enable follows the disable bit at once; only the level lags
    a_tend_drive: assert property (CE_I && CH1_CLOCK_PIN_DISABLE_I |=>
        CH1_DATA_CLOCK_PIN_O == $past(DMA_TRANSFER_END_OUTPUT_0_I))
        else $error("channel-1 pin not carrying DMA end");
    a_tend_enable: assert property (
        CH1_DATA_CLOCK_PIN_OE_O == CH1_CLOCK_PIN_DISABLE_I)
        else $error("channel-1 pin enable does not follow disable bit");
    a_rx_int_gate: assert property (RX_INT_O[0] |->
        ext_reg[0][7] && RECEIVE_FULL_FLAG_I[0])
        else $error("receive interrupt while inhibited");
    a_cts_hold: assert property (CLEAR_TO_SEND_INPUT_0_I |->
        !TRANSMIT_EMPTY_FLAG_O[0])
        else $error("transmit-empty shown while clear-to-send high");
    a_dcd_auto: assert property (!ext_reg[0][6]
        && CARRIER_DETECT_INPUT_0_I
        |-> !RX_ENABLE_O[0] && !RECEIVE_FULL_FLAG_O[0])
        else $error("carrier detect did not gate reception");
    a_send_break: assert property (CE_I && ext_reg[1][0] |=>
        !ASYNC_TRANSMIT_PIN_O[1])
        else $error("send break did not hold transmit low");
    a_break_gated: assert property (CE_I && ext_reg[0][2]
        && !ext_reg[0][1] && !IO_WR_I |=> !ext_reg[0][1])
        else $error("break status set while break handling off");

    c_tend_mode: cover property (CH1_DATA_CLOCK_PIN_OE_O
        && CH1_DATA_CLOCK_PIN_O);
    c_bit_tick: cover property (BIT_TICK_O[0] ##[1:200] BIT_TICK_O[0]);
    c_dma_req: cover property (DMA_REQUEST_INPUT_0_O);
    c_break_seen: cover property (ext_reg[0][1]);
endmodule : acs_ctrl

// [verification/acs_peer.sv]
/*
 * Remote serial peer: modem lines and an external data clock pin.
 * Assumes the bench system clock; drives only at its falling edge.
 */
`timescale 1ns/100ps
module acs_peer (
    // Clock
    input  wire logic clk_i,
    // Line side
    output logic      cts_o,
    output logic      dcd_o,
    output logic      pin_o
);
    initial begin
        cts_o = 1'b0;
        dcd_o = 1'b0;
        pin_o = 1'b0;
    end
    // Modem line levels, high means stop
    task lines(input logic c, input logic d);
        @(negedge clk_i);
        cts_o = c;
        dcd_o = d;
    endtask : lines
    // Clock stands low between bursts; half sets a prompt or slow pace
    task burst(input int n, input int half);
        repeat (n) begin
            repeat (half) @(negedge clk_i);
            pin_o = 1'b1;
            repeat (half) @(negedge clk_i);
            pin_o = 1'b0;
        end
    endtask : burst
endmodule : acs_peer

// [verification/tb_async_serial_clock_and_ext_ctrl.sv]
/*
 * Self-checking bench of the clock-source and extension control block.
 * Assumes acs_pkg compiled first and the peer model alongside.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_async_serial_clock_and_ext_ctrl;
    import acs_pkg::*;
    logic clk, rst, wr_s, rd_s, dis, dma0, tend, rd_q, cnt_en, ce;
    logic [7:0] addr;
    acs_byte_t wdata, rdata, exp_v, exp_q[$];
    acs_tc_t tc1;
    logic [1:0] tx, rff, tef, brk, txp, rff_o, tef_o, rxi, rxe, txe, st, bt;
    logic p0, p1, dreq, o0, oe0, o1, oe1, cts, dcd, pin0, pin1, ch1w;
    int failures, checks_done, cyc, s_cnt, m_cnt, d_cnt, n, i;
    wire logic [3:0] tk = {bt, st};
    assign ch1w = oe1 ? o1 : pin1;
    acs_peer peer0 (.clk_i(clk), .cts_o(cts), .dcd_o(dcd), .pin_o(pin0));
    acs_peer peer1 (.clk_i(clk), .cts_o(), .dcd_o(), .pin_o(pin1));
    acs_ctrl dut (
        .CLK_I(clk), .RESET_I(rst), .CE_I(ce),
        .IO_ADDR_I(addr), .IO_WR_I(wr_s), .IO_RD_I(rd_s),
        .IO_WDATA_I(wdata), .IO_RDATA_O(rdata),
        .CH1_CLOCK_PIN_DISABLE_I(dis), .DMA0_MEM_IO_I(dma0),
        .DMA_TRANSFER_END_OUTPUT_0_I(tend), .DMA_REQUEST_INPUT_0_O(dreq),
        .CH0_DATA_CLOCK_PIN_I(pin0), .CH0_DATA_CLOCK_PIN_O(o0),
        .CH0_DATA_CLOCK_PIN_OE_O(oe0), .CH1_DATA_CLOCK_PIN_I(ch1w),
        .CH1_DATA_CLOCK_PIN_O(o1), .CH1_DATA_CLOCK_PIN_OE_O(oe1),
        .CARRIER_DETECT_INPUT_0_I(dcd), .CLEAR_TO_SEND_INPUT_0_I(cts),
        .TIME_CONST0_I(16'h0010), .TIME_CONST1_I(tc1),
        .TX_DATA_I(tx), .RECEIVE_FULL_FLAG_I(rff),
        .TRANSMIT_EMPTY_FLAG_I(tef), .BREAK_SEEN_I(brk),
        .ASYNC_TRANSMIT_PIN_O(txp), .RECEIVE_FULL_FLAG_O(rff_o),
        .TRANSMIT_EMPTY_FLAG_O(tef_o), .RX_INT_O(rxi), .RX_ENABLE_O(rxe),
        .TX_ENABLE_O(txe), .SAMPLE_TICK_O(st), .BIT_TICK_O(bt));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    // Result watcher: a read answers one edge after it is taken
    always @(posedge clk) begin
        if (rd_q) begin
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
        end
        rd_q <= rd_s & ce & ~rst;
        cyc++;
        if (cyc == 90000) begin
            failures++;
            test_done();
        end
    end
    // Rising edge: pins moved at the falling edge have settled by then
    always @(posedge clk) begin
        if (cnt_en) begin
            s_cnt += int'(st[0]);
            m_cnt += int'(st[0] !== bt[0]);
            d_cnt += int'(dreq !== (dma0 & pin0));
        end
    end
    ////////////////////////////////////////////////////////////////////
    task wr(input logic [7:0] a, input acs_byte_t d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clk);
        wr_s = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input acs_byte_t e);
        @(negedge clk);
        addr = a;
        rd_s = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        rd_s = 1'b0;
    endtask : rd
    task reset_dut();
        @(negedge clk);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
    endtask : reset_dut
    task pulse(input logic [1:0] v);
        @(negedge clk);
        brk = v;
        @(negedge clk);
        brk = 2'b00;
    endtask : pulse
    // Skips two ticks so a reprogrammed counter settles first
    task gap(input int sel, output int cnt);
        cnt = 0;
        repeat (2) begin
            while (tk[sel] !== 1'b1 && cnt < 4000) begin
                @(negedge clk);
                cnt++;
            end
            @(negedge clk);
        end
        cnt = 1;
        while (tk[sel] !== 1'b1 && cnt < 4000) begin
            @(negedge clk);
            cnt++;
        end
    endtask : gap
    task reset_values();
        rd(8'h12, 8'h00);
        rd(8'h13, 8'h00);
        rd(8'h02, 8'h07);
        rd(8'h03, 8'h07);
        rd(8'h55, 8'h00);
    endtask : reset_values
    task test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////
    initial begin
        {rst, wr_s, rd_s, dis, dma0, tend, rd_q, cnt_en} = 8'h80;
        {addr, wdata, tx, rff, tef, brk} = 24'h0;
        {failures, checks_done, cyc, s_cnt, m_cnt, d_cnt} = '0;
        tc1 = 16'h0000;
        ce = 1'b1;
        void'($urandom(32'hf55965c9));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        reset_values();
        wr(8'h12, 8'hff);
        rd(8'h12, 8'hfd);
        wr(8'h13, 8'hff);
        rd(8'h13, 8'h9d);
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h2f);
        wdata = 8'($urandom());
        n = int'(wdata);
        wr(8'h12, wdata);
        rd(8'h12, 8'(n) & 8'hfd);
        // Break status sets only while bit 2 is clear, clears on read
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h04);
        pulse(2'b11);
        rd(8'h12, 8'h02);
        rd(8'h12, 8'h00);
        rd(8'h13, 8'h04);
        for (i = 0; i < 4; i++) begin
            wr(8'h12, {7'h0, i[0]});
            wr(8'h13, {7'h0, i[1]});
            tx = 2'($urandom());
            @(negedge clk);
            `CHK(txp, tx & ~i[1:0])
        end
        for (i = 0; i < 16; i++) begin
            wr(8'h12, {1'b1, i[3], i[2], 5'h00});
            rff = 2'($urandom());
            tef = 2'($urandom());
            peer0.lines(i[1], i[0]);
            @(negedge clk);
            `CHK(rxe, {1'b1, i[3] | ~i[0]})
            `CHK(txe, {1'b1, i[2] | ~i[1]})
            `CHK(rff_o, rff & {1'b1, i[3] | ~i[0]})
            `CHK(tef_o, tef & {1'b1, ~i[1]})
            `CHK({oe0, o0}, 2'b00)
        end
        peer0.lines(1'b0, 1'b0);
        for (i = 0; i < 4; i++) begin
            wr(8'h12, {i[0], 7'h00});
            wr(8'h13, {i[1], 7'h00});
            rff = 2'($urandom());
            @(negedge clk);
            `CHK(rxi, rff & i[1:0])
        end
        for (i = 0; i < 4; i++) begin
            @(negedge clk);
            {dis, tend} = i[1:0];
            @(negedge clk);
            `CHK(oe1, dis)
            `CHK(o1, dis & tend)
        end
        dis = 1'b0;
        // Internal source: every source code, prescale picked at random for each
        for (i = 0; i < 7; i++) begin
            n = int'($urandom() % 2);
            wr(8'h02, {2'b00, n[0], 2'b00, i[2:0]});
            gap(0, n);
            `CHK(n, (wdata[5] ? 30 : 10) << i)
        end
        wr(8'h02, 8'h08);
        gap(2, n);
        `CHK(n, 640)
        wr(8'h02, 8'h00);
        gap(2, n);
        `CHK(n, 160)
        tc1 = 16'(20 + $urandom() % 40);
        wr(8'h03, 8'h00);
        wr(8'h13, 8'h08);
        gap(1, n);
        `CHK(n, int'(tc1) + 1)
        // External clock taken directly as the bit clock
        wr(8'h02, 8'h07);
        wr(8'h12, 8'h10);
        cnt_en = 1'b1;
        peer0.burst(8, 1 + int'($urandom() % 3));
        repeat (8) @(negedge clk);
        `CHK(s_cnt, 8)
        `CHK(m_cnt, 0)
        s_cnt = 0;
        dma0 = 1'b1;
        peer0.burst(4, 2);
        repeat (8) @(negedge clk);
        cnt_en = 1'b0;
        `CHK(s_cnt, 0)
        `CHK(d_cnt, 0)
        dma0 = 1'b0;
        reset_dut();
        reset_values();
        `CHK({oe0, oe1}, 2'b00)
        // Enable low freezes the registers: this write must not land
        ce = 1'b0;
        wr(8'h12, 8'hff);
        ce = 1'b1;
        rd(8'h12, 8'h00);
        repeat (2) @(negedge clk);
        `CHK(exp_q.size(), 0)
        test_done();
    end
endmodule : tb_async_serial_clock_and_ext_ctrl
